// [src/field_out_writer.sv]
// Write side of the field terminals: period check and host I/O area writer.
// Assumes a classic Wishbone master and a host word port that accepts on ready.
//
// Operation
// RQ1: Host keeps scan times (alpha + 2) below 0.9 of each terminal period.
// RQ2: On a period violation the exchange is skipped and counted; refresh must lengthen.
// RQ3: Alpha is 1 for 0 to 18 terminals, one more per group, 14 at most.
// RQ4: Host should keep the period at least 3.3 times its scan time.
// RQ5: On run start, write the area selected by the configured unit number.
// RQ6: Leading word gets 00FF, 0003 or 000F Hex by terminal kind.
// RQ7: Analog values go to words one to eight, four or two after the lead.
// RQ8: Isolated output kind skips the leading word; input kinds write nothing.
// RQ9: Host sets the unit number to match the target unit before running.
// RQ10: Host clears conversion enable on entering program mode; unit holds output.
// RQ11: Conversion enable is forced on while terminals are in use.
// RQ12: After program entry conversion enable is off for one operation cycle.
// RQ13: Host may set the memory hold flag to avoid the brief output change.
// RQ14: Isolated output kind has no conversion enable and converts by default.
// RQ15: Isolated output kind drops to lower limit for one operation cycle.
// RQ16: A status flag shows when the period fails the constraint.
`timescale 1ns/1ns
`default_nettype none
module field_out_writer
  import field_out_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF,
  parameter int CHANNELS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic hio_wr_o,
  output logic [15:0] hio_addr_o,
  output logic [15:0] hio_data_o,
  input wire logic hio_ready_i,
  input wire logic host_program_i,
  input wire logic io_memory_hold_flag_i,
  output logic conv_enable_o,
  output logic low_limit_o,
  output logic period_fault_o
);

  localparam int AW = $clog2(CHANNELS);

  logic [31:0] ctrl_r;
  logic [15:0] period_r;
  logic [15:0] scan_r;
  logic [8:0] nodes_r;
  logic [15:0] skip_r;
  logic [31:0] rd_r;
  logic rd_mem_r;
  logic ack_r;
  logic [31:0] pre_r;
  logic [15:0] ms_r;
  logic op_tick;
  logic [3:0] alpha;
  logic [31:0] lhs;
  logic [31:0] rhs;
  logic fault;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [3:0] idx_r;
  logic [AW-1:0] seq_raddr;
  logic [15:0] seq_rdata;
  logic [15:0] bus_rdata;
  logic prog_d_r;
  logic drop_r;
  logic [15:0] mask;
  logic [3:0] nvals;
  logic has_flag;
  logic writes;
  logic run;
  logic wb_req;
  logic wb_wr;
  logic mem_hit;
  term_type_t ttype;

  assign run = ctrl_r[CTRL_RUN_BIT];
  assign ttype = term_type_t'(ctrl_r[CTRL_TYPE_LSB +: 4]);
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_wr = wb_req & wb_we_i;
  assign mem_hit = (wb_adr_i[7:5] == VALUE_OFS[7:5]);

  // Merge byte lanes of a bus write into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Narrow registers take their merged write value from a named word, since a function result cannot be sliced.
  logic [31:0] period_m, scan_m, nodes_m;
  assign period_m = merge({16'h0000, period_r}, wb_dat_i, wb_sel_i);
  assign scan_m = merge({16'h0000, scan_r}, wb_dat_i, wb_sel_i);
  assign nodes_m = merge({23'h000000, nodes_r}, wb_dat_i, wb_sel_i);

  // Terminal kind decode: mask, value count and whether a conversion flag exists.
  always_comb begin
    mask = 16'h0000;
    nvals = 4'h0;
    has_flag = 1'b1;
    writes = 1'b1;
    case (ttype)
      TT_AO8, TT_AO8B: begin
        mask = MASK_8CH; // [RQ6]
        nvals = 4'h8; // [RQ7]
      end
      TT_MIX2: begin
        mask = MASK_2CH; // [RQ6]
        nvals = 4'h2; // [RQ7]
      end
      TT_MIX4, TT_AO4: begin
        mask = MASK_4CH; // [RQ6]
        nvals = 4'h4; // [RQ7]
      end
      TT_ISO4: begin
        nvals = 4'h4; // [RQ8]
        has_flag = 1'b0; // [RQ14]
      end
      default: begin
        writes = 1'b0; // [RQ8]
        has_flag = 1'b0;
      end
    endcase
  end

  // Alpha grows by one per group of terminals; the table's first group is one short.
  always_comb begin
    if (nodes_r > NODES_LAST) begin
      alpha = ALPHA_MAX; // [RQ3]
    end else begin
      alpha = 4'((nodes_r + 9'h001) / NODES_GROUP) + 4'h1; // [RQ3]
    end
  end

  // Both sides are scaled by ten so the 0.9 factor stays in integers.
  assign lhs = 32'(scan_r) * (32'(alpha) + 32'(ALPHA_ADD)) * 32'(RATIO_DEN);
  assign rhs = 32'(period_r) * 32'(RATIO_NUM);
  assign fault = ~(lhs < rhs); // [RQ1] [RQ16]

  // Control registers written by software steer the sequencer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      period_r <= PERIOD_RST;
      scan_r <= SCAN_RST;
      nodes_r <= NODES_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        CTRL_OFS: ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
        PERIOD_OFS: period_r <= period_m[15:0];
        SCAN_OFS: scan_r <= scan_m[15:0];
        NODES_OFS: nodes_r <= nodes_m[8:0];
        default: ;
      endcase
    end
  end

  // Bus answer: ack one cycle after the request, registered data alongside.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      rd_mem_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
      rd_mem_r <= wb_req & mem_hit;
      rd_r <= 32'h0000_0000;
      if (wb_req & ~wb_we_i) begin
        case (wb_adr_i)
          CTRL_OFS: rd_r <= ctrl_r;
          PERIOD_OFS: rd_r <= {16'h0000, period_r};
          SCAN_OFS: rd_r <= {16'h0000, scan_r};
          NODES_OFS: rd_r <= {23'h000000, nodes_r};
          STATUS_OFS: begin
            rd_r[ST_FAULT_BIT] <= fault; // [RQ16]
            rd_r[ST_CONV_BIT] <= conv_enable_o;
            rd_r[ST_BUSY_BIT] <= (state_r != S_IDLE);
            rd_r[ST_DROP_BIT] <= drop_r;
            rd_r[ST_ALPHA_LSB +: 4] <= alpha;
            rd_r[ST_SKIP_LSB +: 16] <= skip_r;
          end
          default: ;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_mem_r ? {16'h0000, bus_rdata} : rd_r;

  // Operation cycle timebase: a millisecond prescaler and a period counter.
  always_ff @(posedge clk_i) begin
    if (rst_i || !run) begin
      pre_r <= 32'h0000_0000;
      ms_r <= 16'h0000;
    end else if (pre_r == 32'(CYCLES_PER_MS - 1)) begin
      pre_r <= 32'h0000_0000;
      ms_r <= (ms_r + 16'h0001 >= period_r) ? 16'h0000 : ms_r + 16'h0001;
    end else begin
      pre_r <= pre_r + 32'h0000_0001;
    end
  end

  assign op_tick = run && (pre_r == 32'(CYCLES_PER_MS - 1)) && (ms_r + 16'h0001 >= period_r);

  // Sequencer: on an operation cycle that finds it idle with no period fault, write the mask if the kind has one, then the values.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (op_tick && writes && !fault) begin // [RQ2] [RQ5]
          state_nxt = S_PREP;
        end
      end
      S_PREP: state_nxt = has_flag ? S_MASK : S_VAL; // [RQ8]
      S_MASK: begin
        if (hio_ready_i) begin
          state_nxt = S_VAL;
        end
      end
      S_VAL: begin
        if (hio_ready_i && (idx_r + 4'h1 == nvals)) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Value index advances as the host accepts each value word.
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r == S_IDLE) begin
      idx_r <= 4'h0;
    end else if (state_r == S_VAL && hio_ready_i) begin
      idx_r <= idx_r + 4'h1;
    end
  end

  // Read ahead so the next value is ready the cycle after an accept.
  assign seq_raddr = (state_r == S_VAL && hio_ready_i) ? AW'(idx_r + 4'h1) : AW'(idx_r);

  // A tick that finds a period fault or a busy sequencer is a skipped exchange.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_r <= 16'h0000;
    end else if (op_tick && writes && (fault || state_r != S_IDLE) && skip_r != 16'hFFFF) begin
      skip_r <= skip_r + 16'h0001; // [RQ2]
    end
  end

  // Host word port: leading word n, then n+1 onward, all from the unit number.
  always_comb begin
    hio_wr_o = (state_r == S_MASK) || (state_r == S_VAL);
    hio_addr_o = AREA_BASE + 16'(ctrl_r[CTRL_UNIT_LSB +: 8]) * AREA_SPAN; // [RQ5] [RQ9]
    hio_data_o = mask; // [RQ6]
    if (state_r == S_VAL) begin
      hio_addr_o = hio_addr_o + 16'(idx_r) + 16'h0001; // [RQ7]
      hio_data_o = seq_rdata; // [RQ7]
    end
  end

  // Program entry drops conversion until the next operation cycle tick unless memory hold is set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_d_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      prog_d_r <= host_program_i;
      if (host_program_i && !prog_d_r && !io_memory_hold_flag_i && run) begin
        drop_r <= 1'b1; // [RQ10] [RQ12] [RQ13] [RQ15]
      end else if (op_tick) begin
        drop_r <= 1'b0; // [RQ12]
      end
    end
  end

  // Flag outputs are registered so they change only on clock edges.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_enable_o <= 1'b0;
      low_limit_o <= 1'b0;
      period_fault_o <= 1'b0;
    end else begin
      conv_enable_o <= run && has_flag && !drop_r; // [RQ11] [RQ12]
      low_limit_o <= run && (ttype == TT_ISO4) && drop_r; // [RQ14] [RQ15]
      period_fault_o <= fault; // [RQ16]
    end
  end

  value_store #(
    .DEPTH(CHANNELS),
    .WIDTH(16),
    .AW(AW)
  ) u_store (
    .clk_i(clk_i),
    .we_i(wb_wr && mem_hit && wb_sel_i[1:0] == 2'b11),
    .waddr_i(wb_adr_i[AW+1:2]),
    .wdata_i(wb_dat_i[15:0]),
    .raddr_a_i(seq_raddr),
    .rdata_a_o(seq_rdata),
    .raddr_b_i(wb_adr_i[AW+1:2]),
    .rdata_b_o(bus_rdata)
  );

endmodule
`default_nettype wire

// [inc/field_out_pkg.sv]
// Constants shared by the field terminal output writer and its testbench.
// Assumes a 32-bit classic Wishbone register bus and a 16-bit host word port.
package field_out_pkg;

  // Clock and timing.
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] SCAN_OFS = 8'h08;
  localparam logic [7:0] NODES_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] VALUE_OFS = 8'h20;

  // Control field positions.
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_TYPE_LSB = 4;
  localparam int CTRL_UNIT_LSB = 8;

  // Status field positions.
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_CONV_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_DROP_BIT = 3;
  localparam int ST_ALPHA_LSB = 8;
  localparam int ST_SKIP_LSB = 16;

  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RST = 16'h0064;
  localparam logic [15:0] SCAN_RST = 16'h000A;
  localparam logic [8:0] NODES_RST = 9'h000;

  // Host area layout: leading word n = base + unit * span.
  localparam logic [15:0] AREA_BASE = 16'h0000;
  localparam logic [15:0] AREA_SPAN = 16'h000A;

  // Channel-enable masks.
  localparam logic [15:0] MASK_8CH = 16'h00FF;
  localparam logic [15:0] MASK_2CH = 16'h0003;
  localparam logic [15:0] MASK_4CH = 16'h000F;

  // Period check: scan * (alpha + 2) * 10 < period * 9.
  localparam logic [3:0] ALPHA_ADD = 4'h2;
  localparam logic [3:0] RATIO_NUM = 4'h9;
  localparam logic [3:0] RATIO_DEN = 4'hA;
  localparam logic [3:0] ALPHA_MAX = 4'hE;
  localparam logic [8:0] NODES_GROUP = 9'h014;
  localparam logic [8:0] NODES_LAST = 9'h116;

  // Terminal kinds as held in the control register.
  typedef enum logic [3:0] {
    TT_INPUT = 4'h0,
    TT_AO8 = 4'h1,
    TT_MIX2 = 4'h2,
    TT_MIX4 = 4'h3,
    TT_ISO4 = 4'h4,
    TT_AO8B = 4'h5,
    TT_AO4 = 4'h6
  } term_type_t;

  // Write sequencer states, one-hot.
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_PREP = 4'b0010,
    S_MASK = 4'b0100,
    S_VAL = 4'b1000
  } seq_state_t;

endpackage

// [src/value_store.sv]
// Small store of analog output values, one write port and two read ports.
// Assumes one clock; read data appear from a register one cycle after the address.
`timescale 1ns/1ns
`default_nettype none
module value_store #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_a_i,
  output logic [WIDTH-1:0] rdata_a_o,
  input wire logic [AW-1:0] raddr_b_i,
  output logic [WIDTH-1:0] rdata_b_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Contents are left unreset; software loads values before starting a run.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Both read ports are registered so the sequencer and the bus see stable data.
  always_ff @(posedge clk_i) begin
    rdata_a_o <= mem[raddr_a_i];
    rdata_b_o <= mem[raddr_b_i];
  end

endmodule
`default_nettype wire

// [verif/host_io_model.sv]
// Host I/O area model: a word memory written on each accepted beat.
// Assumes one clock; slow_i makes ready alternate so the writer must hold.
`timescale 1ns/1ns
`default_nettype none
module host_io_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic hio_wr_i,
  input wire logic [15:0] hio_addr_i,
  input wire logic [15:0] hio_data_i,
  output logic hio_ready_o
);
  logic [15:0] mem [0:255];
  logic tgl_r = 1'b0;
  // A slow host accepts every other cycle, like a busy scan.
  assign hio_ready_o = !slow_i || tgl_r;
  // Untouched words keep a marker, so stray or missing writes show.
  always @(posedge clk_i) begin
    tgl_r <= !tgl_r;
    if (hio_wr_i && hio_ready_o) mem[hio_addr_i[7:0]] <= hio_data_i;
  end
  initial for (int i = 0; i < 256; i++) mem[i] = 16'hA5A5;
endmodule
`default_nettype wire

// [verif/field_out_writer_assertions.sv]
// Port checker for the field output writer.
// Assumes binding into field_out_writer; one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module field_out_writer_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic hio_wr_o,
  input wire logic [15:0] hio_addr_o,
  input wire logic [15:0] hio_data_o,
  input wire logic hio_ready_i,
  input wire logic host_program_i,
  input wire logic io_memory_hold_flag_i,
  input wire logic conv_enable_o,
  input wire logic low_limit_o,
  input wire logic period_fault_o
);
  // One clock domain; reset masks every check but the reset one.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answers come once, one cycle late, and only when asked.
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack wider than a cycle");
  AST_ACK_DUE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_RESET_QUIET: assert property (disable iff (1'b0) rst_i |=> !hio_wr_o && !wb_ack_o && !conv_enable_o)
    else $error("outputs active after reset");
  // Host beats stand until taken and walk up the area word by word.
  AST_HIO_HOLD: assert property (hio_wr_o && !hio_ready_i |=> hio_wr_o && $stable(hio_addr_o) && $stable(hio_data_o))
    else $error("host beat changed before accept");
  AST_HIO_NEXT: assert property (hio_wr_o && hio_ready_i ##1 hio_wr_o |-> hio_addr_o == $past(hio_addr_o) + 16'h0001)
    else $error("host address not consecutive");
  // Program entry: a brief drop unless the hold flag is set.
  AST_PROG_DROP: assert property ($rose(host_program_i) && !io_memory_hold_flag_i && conv_enable_o |-> ##[1:3] (!conv_enable_o || low_limit_o))
    else $error("no drop on program entry");
  AST_HOLD_FLAG: assert property ($rose(host_program_i) && io_memory_hold_flag_i && conv_enable_o |=> conv_enable_o [*3])
    else $error("drop despite hold flag");
  // A standing fault keeps the exchange from starting.
  AST_FAULT_SKIP: assert property (period_fault_o [*4] |-> !$rose(hio_wr_o))
    else $error("exchange during period fault");
endmodule
bind field_out_writer field_out_writer_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .hio_wr_o(hio_wr_o), .hio_addr_o(hio_addr_o),
  .hio_data_o(hio_data_o), .hio_ready_i(hio_ready_i), .host_program_i(host_program_i),
  .io_memory_hold_flag_i(io_memory_hold_flag_i), .conv_enable_o(conv_enable_o),
  .low_limit_o(low_limit_o), .period_fault_o(period_fault_o));
`default_nettype wire

// [verif/tb_field_out_writer.sv]
// Bench for the field output writer: bus tasks, host model, checks.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module tb_field_out_writer;
  import field_out_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic slow = 1'b0, prog = 1'b0, hold = 1'b0, rdy, hwr, ack, conv, low, flt;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [15:0] ha, hd;
  logic [31:0] dw = 32'h0, dr, rd;
  int fail_count = 0, total_checks = 0, cyc_n = 0, n;
  logic [7:0] ra [5] = '{CTRL_OFS, PERIOD_OFS, SCAN_OFS, NODES_OFS, 8'h18};
  logic [31:0] rv [5] = '{CTRL_RST, {16'h0, PERIOD_RST}, {16'h0, SCAN_RST}, {23'h0, NODES_RST}, 32'h0};
  logic [15:0] mk [7] = '{16'hA5A5, MASK_8CH, MASK_2CH, MASK_4CH, 16'hA5A5, MASK_8CH, MASK_4CH};
  int nv [7] = '{0, 8, 2, 4, 4, 8, 4};
  logic [8:0] an [7] = '{9'h012, 9'h013, 9'h026, 9'h027, 9'h102, 9'h103, 9'h116};
  logic [3:0] ax [7] = '{4'h1, 4'h2, 4'h2, 4'h3, 4'hD, 4'hE, 4'hE};

  field_out_writer #(.CYCLES_PER_MS(4), .CHANNELS(8)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .hio_wr_o(hwr), .hio_addr_o(ha), .hio_data_o(hd),
    .hio_ready_i(rdy), .host_program_i(prog), .io_memory_hold_flag_i(hold),
    .conv_enable_o(conv), .low_limit_o(low), .period_fault_o(flt));
  host_io_model hm (.clk_i(clk_i), .slow_i(slow), .hio_wr_i(hwr), .hio_addr_i(ha),
    .hio_data_i(hd), .hio_ready_o(rdy));

  // Clock at 250 MHz.
  always #2 clk_i = ~clk_i;

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // A hang is cut short here and counted as a mismatch.
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // Classic single cycle; read data are taken at the edge that sees ack.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Main sequence: reset values, every terminal kind, then the period check.
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      `CHK(rd, rv[i])
    end
    $display("test reset values done");
    bus(1'b1, PERIOD_OFS, 32'h28);
    for (int i = 0; i < 8; i++) bus(1'b1, 8'(VALUE_OFS + 4 * i), 32'h1100 + i);
    for (int t = 0; t < 7; t++) begin
      slow <= t[0];
      n = AREA_BASE + t * AREA_SPAN;
      bus(1'b1, CTRL_OFS, {16'h0, 8'(t), 4'(t), 4'h1});
      repeat (200) @(posedge clk_i);
      if (t > 2 && t < 6) begin
        hold <= (t == 5);
        prog <= 1'b1;
        repeat (3) @(posedge clk_i);
        if (t == 4) `CHK(low, 1'b1)
        else `CHK(conv, 1'(t == 5))
        prog <= 1'b0;
      end
      repeat (400) @(posedge clk_i);
      `CHK(low, 1'b0)
      if (t != 0 && t != 4) `CHK(conv, 1'b1)
      bus(1'b1, CTRL_OFS, 32'h0);
      `CHK(hm.mem[n], mk[t])
      for (int k = 1; k < 9; k++) `CHK(hm.mem[n + k], (k <= nv[t]) ? 16'(16'h10FF + k) : 16'hA5A5)
    end
    $display("test terminal kinds done");
    bus(1'b1, SCAN_OFS, 32'h19);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, NODES_OFS, {23'h0, an[i]});
      bus(1'b0, STATUS_OFS, 32'h0);
      `CHK(rd[11:8], ax[i])
    end
    bus(1'b1, NODES_OFS, 32'h32);
    for (int p = 'h8A; p < 'h8C; p++) begin
      bus(1'b1, PERIOD_OFS, 32'(p));
      repeat (3) @(posedge clk_i);
      `CHK(flt, 1'(p == 'h8A))
    end
    bus(1'b1, PERIOD_OFS, 32'h8A);
    bus(1'b1, CTRL_OFS, 32'h0911);
    repeat (1200) @(posedge clk_i);
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK(rd[31:16] != 16'h0, 1'b1)
    `CHK(hm.mem[90], 16'hA5A5)
    $display("test period check done");
    report_and_stop();
  end
endmodule
`default_nettype wire
